// >>> stt_timer.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// R1 - Count clock divides system clock or doubled RC clock; external source optional.
// R2 - Sixteen-bit counter clears, increments or decrements per count clock by mode.
// R3 - Count 0x0000 is bottom; counter increments from bottom.
// R4 - Top is 0xFFFF, fixed value, compare A or capture; then clear or reverse.
// R5 - Count equal to compare A or B sets match flag; request if enabled.
// R6 - Overflow sets overflow flag; request if enabled.
// R7 - PWM modes double-buffer compares, updated at top or bottom; else unbuffered.
// R8 - Dead time inserts a gap of programmed count clocks into the waveform.
// R9 - Output mode field zero stops driving that waveform output.
// R10 - Sixteen modes chosen by four-bit waveform mode field; the code decodes fifteen modes in five classes, code 13 acting as mode 0.
// R11 - Mode 0 counts up to 0xFFFF, wraps, sets overflow as count becomes zero.
// R12 - Normal mode overflow flag is only set; service entry clears it.
// R13 - Normal mode with output mode 1 toggles output on each match.
// R14 - Modes 4 and 12 clear on match; top compare A or capture.
// R15 - Clear-on-match mode increments and clears at top.
// R16 - Clear-on-match mode sets match flag when count reaches top; in mode 12 the code sets it only at a count equal to compare A or B.
// R17 - Compare A unbuffered there; value below count is missed until wrap.
// R18 - Clear-on-match mode sets overflow as count wraps to zero.
// R19 - Prescaler divides by 1, 8, 64, 256 or 1024.
// R20 - Modes 5,6,7,14,15 are fast PWM; top fixed, capture or compare A.
// R21 - Fast PWM sets or clears outputs at top or bottom per output mode.
// R22 - Fast PWM at top sets overflow and loads buffered compares.
// R23 - Buffered writes go to buffer only; compare uses active copy until update.
// R24 - Fast PWM match drives output opposite to level applied at bottom.
module stt_timer
  import stt_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock sources and capture trigger
  input wire logic doubled_rc_clock,
  input wire logic ext_count_in,
  input wire logic capture_trigger,
  // Service requests and acknowledges
  output logic [3:0] irq_req,
  input wire logic [3:0] service_ack,
  // Waveform outputs
  output logic waveform_out_a,
  output logic waveform_out_a_en,
  output logic waveform_out_b,
  output logic waveform_out_b_en
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic wave_next(input logic [1:0] com, input stt_class_t c, input logic hit,
                                     input logic bot, input logic down, input logic cur);
    logic lvl;
    lvl = (com == 2'b11);
    wave_next = cur;
    if (com == 2'b01) begin
      if (hit) wave_next = ~cur;
    end else if (com != 2'b00) begin
      if (c == M_FAST && bot) wave_next = ~lvl;
      if (hit) wave_next = ((c == M_PC || c == M_PFC) && down) ? ~lvl : lvl;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [12:0] ctrl_q;
  logic [15:0] cnt_q, cnt_d;
  logic dir_q, dir_d;
  logic [15:0] cmpa_buf_q, cmpb_buf_q, cmpa_act_q, cmpb_act_q, cap_q;
  logic [3:0] flag_q, ien_q;
  logic [7:0] dead_q;
  logic [3:0] wg_mode;
  logic [2:0] cs;
  logic [1:0] com [2];
  stt_class_t cls;
  logic [15:0] top;
  logic cap_is_top, pwm, tick, upd, ovf_ev, bot_ev;
  logic [1:0] hit;
  logic wr_go, cnt_wr, cmpa_wr, cmpb_wr;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_full_q, w_full_q;

  assign wg_mode = ctrl_q[WGM_LSB +: 4];
  assign cs = ctrl_q[CS_LSB +: 3];
  assign com[0] = ctrl_q[COMA_LSB +: 2];
  assign com[1] = ctrl_q[COMB_LSB +: 2];

  // Mode class and top value from the waveform mode field
  always_comb begin
    cls = M_NORMAL;
    top = MAX;
    cap_is_top = 1'b0;
    case (wg_mode)
      4'd0: cls = M_NORMAL;
      4'd1: begin cls = M_PC; top = TOP_8; end
      4'd2: begin cls = M_PC; top = TOP_9; end
      4'd3: begin cls = M_PC; top = TOP_10; end
      4'd4: begin cls = M_CTC; top = cmpa_act_q; end // R14
      4'd5: begin cls = M_FAST; top = TOP_8; end // R20
      4'd6: begin cls = M_FAST; top = TOP_9; end
      4'd7: begin cls = M_FAST; top = TOP_10; end
      4'd8: begin cls = M_PFC; top = cap_q; cap_is_top = 1'b1; end
      4'd9: begin cls = M_PFC; top = cmpa_act_q; end
      4'd10: begin cls = M_PC; top = cap_q; cap_is_top = 1'b1; end
      4'd11: begin cls = M_PC; top = cmpa_act_q; end
      4'd12: begin cls = M_CTC; top = cap_q; cap_is_top = 1'b1; end // R14
      4'd14: begin cls = M_FAST; top = cap_q; cap_is_top = 1'b1; end
      4'd15: begin cls = M_FAST; top = cmpa_act_q; end
      default: cls = M_NORMAL;
    endcase
  end
  assign pwm = (cls == M_FAST) || (cls == M_PC) || (cls == M_PFC); // R7

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  logic [9:0] pre_q;
  logic ext_prev_q, pre_en;

  // Prescaler steps on system clock or doubled RC clock enable
  assign pre_en = ctrl_q[SRC_BIT] ? doubled_rc_clock : 1'b1; // R1
  always_ff @(posedge aclk) begin
    if (!aresetn) pre_q <= 10'h000;
    else if (cs == CS_STOP) pre_q <= 10'h000;
    else if (pre_en) pre_q <= pre_q + 10'h001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ext_prev_q <= 1'b0;
    else ext_prev_q <= ext_count_in;
  end

  // Division factor selection
  always_comb begin
    case (cs)
      CS_DIV1: tick = pre_en; // R19
      CS_DIV8: tick = pre_en && (&pre_q[2:0]);
      CS_DIV64: tick = pre_en && (&pre_q[5:0]);
      CS_DIV256: tick = pre_en && (&pre_q[7:0]);
      CS_DIV1024: tick = pre_en && (&pre_q[9:0]);
      CS_EXT_FALL: tick = ext_prev_q && !ext_count_in; // R1
      CS_EXT_RISE: tick = !ext_prev_q && ext_count_in;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (tick) begin
      case (cls)
        M_CTC, M_FAST: cnt_d = (cnt_q == top) ? BOTTOM : cnt_q + 16'h0001; // R4 R15 R20
        M_PC, M_PFC: begin
          if (!dir_q && cnt_q >= top) begin // R4
            dir_d = 1'b1;
            cnt_d = cnt_q - 16'h0001;
          end else if (dir_q && cnt_q == BOTTOM) begin // R3
            dir_d = 1'b0;
            cnt_d = cnt_q + 16'h0001;
          end else begin
            cnt_d = dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001; // R2
          end
        end
        default: cnt_d = cnt_q + 16'h0001; // R11
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= BOTTOM;
      dir_q <= 1'b0;
    end else if (cnt_wr) begin
      cnt_q <= merge16(cnt_q, w_data_q, w_strb_q);
      dir_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // Events of the current count clock
  assign hit[0] = tick && (cnt_q == cmpa_act_q); // R5 R16 R17
  assign hit[1] = tick && (cnt_q == cmpb_act_q);
  assign bot_ev = tick && (cnt_d == BOTTOM) && (cnt_q != BOTTOM);
  always_comb begin
    case (cls)
      M_FAST: begin
        ovf_ev = tick && (cnt_q == top); // R22
        upd = ovf_ev;
      end
      M_PC: begin
        ovf_ev = bot_ev && dir_q;
        upd = tick && !dir_q && (cnt_q >= top);
      end
      M_PFC: begin
        ovf_ev = bot_ev && dir_q;
        upd = ovf_ev;
      end
      default: begin
        ovf_ev = tick && (cnt_q == MAX); // R11 R18
        upd = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Compare and capture registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpa_buf_q <= BOTTOM;
      cmpa_act_q <= BOTTOM;
    end else begin
      if (cmpa_wr) cmpa_buf_q <= merge16(cmpa_buf_q, w_data_q, w_strb_q); // R23
      if (cmpa_wr && !pwm) cmpa_act_q <= merge16(cmpa_buf_q, w_data_q, w_strb_q); // R7 R17
      else if (pwm && upd) cmpa_act_q <= cmpa_buf_q; // R7 R22
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpb_buf_q <= BOTTOM;
      cmpb_act_q <= BOTTOM;
    end else begin
      if (cmpb_wr) cmpb_buf_q <= merge16(cmpb_buf_q, w_data_q, w_strb_q); // R23
      if (cmpb_wr && !pwm) cmpb_act_q <= merge16(cmpb_buf_q, w_data_q, w_strb_q); // R7
      else if (pwm && upd) cmpb_act_q <= cmpb_buf_q; // R7 R22
    end
  end
  // Capture latches the count unless capture is the top
  always_ff @(posedge aclk) begin
    if (!aresetn) cap_q <= BOTTOM;
    else if (wr_go && aw_addr_q == ADDR_CAP) cap_q <= merge16(cap_q, w_data_q, w_strb_q);
    else if (capture_trigger && !cap_is_top) cap_q <= cnt_q; // R10
  end

  // ----------------------------------------------------------------
  // Flags, set wins over clear
  // ----------------------------------------------------------------
  logic [3:0] flag_set, flag_clr;
  assign flag_set = {capture_trigger && !cap_is_top, hit[1], hit[0], ovf_ev}; // R5 R6
  assign flag_clr = service_ack | ((wr_go && aw_addr_q == ADDR_FLAG && w_strb_q[0]) ? w_data_q[3:0] : 4'h0); // R12
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_q <= 4'h0;
    else flag_q <= (flag_q & ~flag_clr) | flag_set;
  end
  assign irq_req = flag_q & ien_q; // R5 R6

  // ----------------------------------------------------------------
  // Waveform and dead time
  // ----------------------------------------------------------------
  logic [1:0] wave_q, out_q, oe_q;
  logic [3:0] dt_q [2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_q <= 2'b00;
      out_q <= 2'b00;
      oe_q <= 2'b00;
      dt_q[0] <= 4'h0;
      dt_q[1] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        wave_q[i] <= wave_next(com[i], cls, hit[i], bot_ev, dir_q, wave_q[i]); // R13 R21 R24
        oe_q[i] <= (com[i] != 2'b00); // R9
        if (!ctrl_q[DTEN_BIT]) begin
          out_q[i] <= wave_q[i];
        end else if (!wave_q[i]) begin
          out_q[i] <= 1'b0;
          dt_q[i] <= dead_q[4*i +: 4]; // R8
        end else if (dt_q[i] != 4'h0) begin
          out_q[i] <= 1'b0;
          if (tick) dt_q[i] <= dt_q[i] - 4'h1; // R8
        end else begin
          out_q[i] <= 1'b1;
        end
      end
    end
  end
  assign waveform_out_a = out_q[0];
  assign waveform_out_b = out_q[1];
  assign waveform_out_a_en = oe_q[0];
  assign waveform_out_b_en = oe_q[1];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign cnt_wr = wr_go && aw_addr_q == ADDR_COUNT;
  assign cmpa_wr = wr_go && aw_addr_q == ADDR_CMPA;
  assign cmpb_wr = wr_go && aw_addr_q == ADDR_CMPB;

  // Address and data capture in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) aw_full_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) w_full_q <= 1'b0;
    end
  end

  // Software controlled configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      ien_q <= 4'h0;
      dead_q <= 8'h00;
    end else if (wr_go) begin
      if (aw_addr_q == ADDR_CTRL && w_strb_q[0]) ctrl_q[7:0] <= w_data_q[7:0]; // R10
      if (aw_addr_q == ADDR_CTRL && w_strb_q[1]) ctrl_q[12:8] <= w_data_q[12:8];
      if (aw_addr_q == ADDR_IEN && w_strb_q[0]) ien_q <= w_data_q[3:0];
      if (aw_addr_q == ADDR_DEAD && w_strb_q[0]) dead_q <= w_data_q[7:0];
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q[7:5] == 3'h0 && aw_addr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  // Read data mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_CTRL: rd_mux = {19'h00000, ctrl_q};
      ADDR_COUNT: rd_mux = {16'h0000, cnt_q};
      ADDR_CMPA: rd_mux = {16'h0000, cmpa_buf_q};
      ADDR_CMPB: rd_mux = {16'h0000, cmpb_buf_q};
      ADDR_CAP: rd_mux = {16'h0000, cap_q};
      ADDR_FLAG: rd_mux = {28'h0000000, flag_q};
      ADDR_IEN: rd_mux = {28'h0000000, ien_q};
      ADDR_DEAD: rd_mux = {24'h000000, dead_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wrap_normal;
    cls == M_NORMAL && tick && cnt_q == MAX && !cnt_wr;
  endsequence
  sequence s_toggle_a;
    cls == M_NORMAL && com[0] == 2'b01 && hit[0];
  endsequence
  sequence s_fast_top;
    cls == M_FAST && tick && cnt_q == top && !cnt_wr && !cmpa_wr;
  endsequence

  property p_normal_wrap;
    s_wrap_normal |=> cnt_q == BOTTOM && flag_q[FLG_OVF];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap lost"); // R11
  property p_ctc_clear;
    cls == M_CTC && tick && cnt_q == top && !cnt_wr |=> cnt_q == BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("top did not clear count"); // R15
  property p_match_flag;
    hit[0] |=> flag_q[FLG_MA] ##1 (flag_q[FLG_MA] || $past(flag_clr[FLG_MA]));
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag missing"); // R5
  property p_fast_update;
    s_fast_top |=> cmpa_act_q == $past(cmpa_buf_q) && flag_q[FLG_OVF] && cnt_q == BOTTOM;
  endproperty
  a_fast_update: assert property (p_fast_update) else $error("fast top update missing"); // R22
  property p_unbuffered;
    !pwm && cmpa_wr && $stable(ctrl_q) |=> cmpa_act_q == cmpa_buf_q;
  endproperty
  a_unbuffered: assert property (p_unbuffered) else $error("unbuffered write not active"); // R7
  property p_buffer_hold;
    pwm && cmpa_wr && !upd |=> $stable(cmpa_act_q);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("buffered write reached compare"); // R23
  property p_output_off;
    com[0] == 2'b00 ##1 com[0] == 2'b00 |-> !waveform_out_a_en;
  endproperty
  a_output_off: assert property (p_output_off) else $error("output driven while off"); // R9
  property p_toggle;
    s_toggle_a |=> wave_q[0] != $past(wave_q[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match"); // R13
  property p_bottom_up;
    tick && cnt_q == BOTTOM && !cnt_wr && top != BOTTOM && cls != M_NORMAL |=> cnt_q == 16'h0001;
  endproperty
  a_bottom_up: assert property (p_bottom_up) else $error("bottom did not increment"); // R3

endmodule // stt_timer

// >>> stt_pkg.sv
package stt_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMPA = 8'h08;
  localparam logic [7:0] ADDR_CMPB = 8'h0C;
  localparam logic [7:0] ADDR_CAP = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;
  localparam logic [7:0] ADDR_IEN = 8'h18;
  localparam logic [7:0] ADDR_DEAD = 8'h1C;
  // Control register fields
  localparam int WGM_LSB = 0;
  localparam int CS_LSB = 4;
  localparam int SRC_BIT = 7;
  localparam int COMA_LSB = 8;
  localparam int COMB_LSB = 10;
  localparam int DTEN_BIT = 12;
  localparam logic [12:0] CTRL_RST = 13'h0000;
  // Flag bits
  localparam int FLG_OVF = 0;
  localparam int FLG_MA = 1;
  localparam int FLG_MB = 2;
  localparam int FLG_CAP = 3;
  // Count limits
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Mode classes
  typedef enum logic [2:0] {
    M_NORMAL = 3'b000,
    M_CTC = 3'b001,
    M_FAST = 3'b010,
    M_PC = 3'b011,
    M_PFC = 3'b100
  } stt_class_t;
endpackage

// >>> stt_timer_tb.sv
`timescale 1ns/1ps
module stt_timer_tb;
  import stt_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rc_en, ext_in, cap_trig;
  logic wa, wa_en, wb, wb_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, v;
  logic [3:0] wstrb, irq_req, service_ack;
  logic [1:0] bresp, rresp, rs;
  int err_count, tests_run, hi;
  integer seed;
  stt_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .doubled_rc_clock(rc_en),
    .ext_count_in(ext_in), .capture_trigger(cap_trig), .irq_req(irq_req), .service_ack(service_ack),
    .waveform_out_a(wa), .waveform_out_a_en(wa_en), .waveform_out_b(wb), .waveform_out_b_en(wb_en));
  // Free-running system clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ao, wo;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Address and data released separately as each is taken
    do begin
      @(negedge aclk);
      ao = awvalid && awready;
      wo = wvalid && wready;
      n++;
      @(posedge aclk);
      if (ao) awvalid <= 1'b0;
      if (wo) wvalid <= 1'b0;
      #1;
    end while ((awvalid || wvalid) && n < 100);
    while (bvalid !== 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    bready <= 1'b0;
    chk(32'(n < 100), 32'h1);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    chk(32'(n < 100), 32'h1);
  endtask
  function automatic logic [31:0] ctl(input int wgm, input logic [2:0] cs, input int coma, input int dten);
    return 32'(wgm) | (32'(cs) << CS_LSB) | (32'(coma) << COMA_LSB) | (32'(dten) << DTEN_BIT);
  endfunction
  // High cycles over four fast PWM periods of 256 ticks
  function automatic int duty(input int cmp, input int dead);
    return 4 * (cmp + 1 - dead);
  endfunction
  task automatic run(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic measure(input int e);
    hi = 0;
    repeat (1024) begin
      @(negedge aclk);
      if (wa === 1'b1) hi++;
    end
    chk(32'(hi >= e - 4 && hi <= e + 4), 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #500000;
    err_count++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rc_en, ext_in, cap_trig} = '0;
    {awaddr, araddr, wdata, service_ack} = '0;
    wstrb = 4'hF;
    seed = 32'h801c6666;
    run(8);
    aresetn <= 1'b1;
    rd_reg(ADDR_CTRL);
    chk(rd, 32'h0);
    rd_reg(8'h20);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0);
    repeat (4) begin
      v = $random(seed);
      wr(ADDR_DEAD, v);
      rd_reg(ADDR_DEAD);
      chk(rd, v & 32'hFF);
    end
    $display("test registers done");
    // Normal mode: wrap, toggle on match, service clears overflow
    wr(ADDR_CMPA, 32'hFFF8);
    wr(ADDR_CMPB, 32'hFFF4);
    wr(ADDR_COUNT, 32'hFFF0);
    wr(ADDR_CTRL, ctl(0, CS_DIV1, 1, 0));
    run(40);
    wr(ADDR_CTRL, ctl(0, CS_STOP, 1, 0));
    chk(32'(wa), 32'h1);
    chk({30'h0, wb_en, wb}, 32'h0);
    rd_reg(ADDR_FLAG);
    chk(rd & 32'h3, 32'h3);
    chk(rd & 32'h4, 32'h4);
    rd_reg(ADDR_COUNT);
    chk(32'(rd < 32'h80), 32'h1);
    wr(ADDR_IEN, 32'h1);
    @(negedge aclk);
    chk(32'(irq_req[0]), 32'h1);
    @(posedge aclk);
    service_ack <= 4'h1;
    @(posedge aclk);
    service_ack <= 4'h0;
    run(2);
    chk(32'(irq_req[0]), 32'h0);
    wr(ADDR_CTRL, ctl(0, CS_STOP, 0, 0));
    run(2);
    chk(32'(wa_en), 32'h0);
    wr(ADDR_COUNT, 32'h1234);
    @(posedge aclk);
    cap_trig <= 1'b1;
    @(posedge aclk);
    cap_trig <= 1'b0;
    rd_reg(ADDR_CAP);
    chk(rd, 32'h1234);
    $display("test normal done");
    // Clear-on-match with random tops, both top sources
    for (int i = 0; i < 4; i++) begin
      v = 8 + ($random(seed) & 32'h1F);
      wr(ADDR_CTRL, ctl(i[0] ? 12 : 4, CS_STOP, 0, 0));
      wr(ADDR_FLAG, 32'hF);
      wr(ADDR_CMPA, v);
      wr(ADDR_CAP, v);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CTRL, ctl(i[0] ? 12 : 4, CS_DIV1, 0, 0));
      run(150);
      wr(ADDR_CTRL, ctl(i[0] ? 12 : 4, CS_STOP, 0, 0));
      rd_reg(ADDR_COUNT);
      chk(32'(rd <= v), 32'h1);
      rd_reg(ADDR_FLAG);
      chk(rd & 32'h3, 32'h2);
    end
    wr(ADDR_FLAG, 32'hF);
    wr(ADDR_CMPA, 32'h10);
    wr(ADDR_COUNT, 32'h100);
    wr(ADDR_CTRL, ctl(4, CS_DIV1, 0, 0));
    run(50);
    wr(ADDR_CTRL, ctl(4, CS_STOP, 0, 0));
    rd_reg(ADDR_COUNT);
    chk(32'(rd > 32'h130), 32'h1);
    $display("test clear on match done");
    // Fast PWM with 8-bit top: duty, buffered update, dead time
    wr(ADDR_DEAD, 32'h4);
    wr(ADDR_CTRL, ctl(5, CS_STOP, 2, 0));
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CMPA, 32'h40);
    wr(ADDR_CTRL, ctl(5, CS_DIV1, 2, 0));
    run(300);
    measure(duty(32'h40, 0));
    wr(ADDR_CMPA, 32'hC0);
    run(300);
    measure(duty(32'hC0, 0));
    wr(ADDR_CTRL, ctl(5, CS_DIV1, 2, 1));
    run(300);
    measure(duty(32'hC0, 4));
    wr(ADDR_CTRL, ctl(5, CS_STOP, 2, 0));
    rd_reg(ADDR_COUNT);
    chk(32'(rd <= 32'hFF), 32'h1);
    rd_reg(ADDR_FLAG);
    chk(rd & 32'h1, 32'h1);
    $display("test fast pwm done");
    // Phase-correct PWM: count turns at top and bottom
    wr(ADDR_FLAG, 32'hF);
    wr(ADDR_CTRL, ctl(1, CS_DIV1, 2, 0));
    run(700);
    wr(ADDR_CTRL, ctl(1, CS_STOP, 2, 0));
    rd_reg(ADDR_COUNT);
    chk(32'(rd <= 32'hFF), 32'h1);
    rd_reg(ADDR_FLAG);
    chk(rd & 32'h3, 32'h3);
    $display("test phase correct done");
    // Count clock sources and prescaler
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, ctl(0, CS_EXT_RISE, 0, 0));
    repeat (5) begin
      @(posedge aclk);
      ext_in <= 1'b1;
      run(3);
      ext_in <= 1'b0;
      run(3);
    end
    run(4);
    wr(ADDR_CTRL, ctl(0, CS_STOP, 0, 0));
    rd_reg(ADDR_COUNT);
    chk(rd, 32'h5);
    v = 3 + ($random(seed) & 32'h7);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, ctl(0, CS_DIV1, 0, 0) | (32'h1 << SRC_BIT));
    @(posedge aclk);
    rc_en <= 1'b1;
    run(int'(v));
    rc_en <= 1'b0;
    run(4);
    wr(ADDR_CTRL, ctl(0, CS_STOP, 0, 0));
    rd_reg(ADDR_COUNT);
    chk(rd, v);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, ctl(0, CS_DIV8, 0, 0));
    run(80);
    wr(ADDR_CTRL, ctl(0, CS_STOP, 0, 0));
    rd_reg(ADDR_COUNT);
    chk(32'(rd >= 8 && rd <= 12), 32'h1);
    $display("test clock sources done");
    tally_and_finish();
  end
endmodule // stt_timer_tb
